/* File: bench/amd_decoder_bench.sv */
// Self-checking bench for the addressing-mode decoder
`timescale 1ns/1ns
module amd_decoder_bench
  import amd_pkg::*;
;
  logic ref_clk = 1'b0, sys_rst = 1'b1, start = 1'b0, useYIn = 1'b0, rmwIn = 1'b0;
  amd_mode_e modeIn = MODE_INH;
  logic [15:0] opcodeAddr = 16'h0000;
  logic [7:0] xReg = 8'h00, yReg = 8'h00;
  logic [1:0] lag = 2'h0;
  logic memReq, memRvalid, busy, done, illegal;
  logic [15:0] memAddr, effAddr, branchTarget, pcNext;
  logic [7:0] memRdata, operand;
  logic [2:0] instrLen;
  int fails = 0, totalChecks = 0, cycles = 0;

  amd_decoder amd_decoder_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .start(start), .modeIn(modeIn),
    .useYIn(useYIn), .rmwIn(rmwIn), .opcodeAddr(opcodeAddr), .xReg(xReg), .yReg(yReg),
    .memReq(memReq), .memAddr(memAddr), .memRdata(memRdata), .memRvalid(memRvalid), .busy(busy),
    .done(done), .illegal(illegal), .effAddr(effAddr), .operand(operand),
    .branchTarget(branchTarget), .pcNext(pcNext), .instrLen(instrLen));
  amd_mem_model amd_mem_model_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .memReq(memReq),
    .memAddr(memAddr), .lag(lag), .memRdata(memRdata), .memRvalid(memRvalid));

  always #25 ref_clk = ~ref_clk;

  function automatic logic [7:0] mem(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'ha5;
  endfunction

  function automatic logic [1:0] nFetch(input amd_mode_e m);
    if (m inside {MODE_INH, MODE_IDX0})
      return 2'h0;
    return (m inside {MODE_DIRL, MODE_IDXL, MODE_BITDR, MODE_BITIR}) ? 2'h2 : 2'h1;
  endfunction

  function automatic logic [2:0] lenOf(input amd_mode_e m, input logic y);
    if (m == MODE_INH)
      return 3'h1;
    if (m == MODE_IDX0)
      return y ? 3'h2 : 3'h1;
    if (m inside {MODE_IMM, MODE_DIRS, MODE_IDXS, MODE_RELD, MODE_BITD})
      return 3'h2;
    return (m == MODE_BITIR) ? 3'h4 : 3'h3;
  endfunction

  task automatic cmpWord(input logic [15:0] got, input logic [15:0] exp);
    totalChecks++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmpByte(input logic [7:0] got, input logic [7:0] exp);
    cmpWord({8'h00, got}, {8'h00, exp});
  endtask

  task automatic cmpBit(input logic got, input logic exp);
    cmpWord({15'h0000, got}, {15'h0000, exp});
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", totalChecks, fails);
    if (fails == 0 && totalChecks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 10000)
    begin
      fails++;
      conclude();
    end
  end

  // Runs one decode from a point just after a clock edge and checks its results
  task automatic runOne(input amd_mode_e m, input logic y, input logic rmw, input logic [15:0] opc,
                        input logic [7:0] x, input logic [7:0] yv, input logic hold);
    logic [7:0] b0, b1, q0, q1, idx, off;
    logic [15:0] pc, ea, p, firstAddr;
    logic got, sawReq, bad, quick;
    b0 = mem(opc + 16'h1);
    b1 = mem(opc + 16'h2);
    p = {8'h00, b0};
    q0 = mem(p);
    q1 = mem(p + 16'h1);
    idx = y ? yv : x;
    pc = opc + 16'h1 + {14'h0000, nFetch(m)};
    bad = rmw && (m inside {MODE_DIRL, MODE_IDXL, MODE_INDL, MODE_INDIL});
    start = 1'b1;
    modeIn = m;
    useYIn = y;
    rmwIn = rmw;
    opcodeAddr = opc;
    xReg = x;
    yReg = yv;
    lag = 2'($urandom_range(3));
    @(posedge ref_clk);
    #1;
    cmpBit(busy, !bad);
    if (hold && !bad)
    begin
      // A start while busy must be ignored
      modeIn = MODE_BITIR;
      xReg = ~x;
      @(posedge ref_clk);
      #1;
    end
    start = 1'b0;
    got = 1'b0;
    sawReq = 1'b0;
    quick = 1'b1;
    firstAddr = 16'h0000;
    for (int n = 0; n < 80 && !got; n++)
    begin
      got = (done === 1'b1) || (illegal === 1'b1);
      if (!sawReq && memReq === 1'b1)
        firstAddr = memAddr;
      sawReq = sawReq | (memReq === 1'b1);
      if (!got)
      begin
        quick = 1'b0;
        @(posedge ref_clk);
        #1;
      end
    end
    cmpBit(got, 1'b1);
    cmpBit(illegal, bad);
    cmpBit(done, !bad);
    cmpBit(busy, 1'b0);
    if (bad)
    begin
      cmpBit(sawReq, 1'b0);
      // Let a cycle pass before the next start
      @(posedge ref_clk);
      #1;
      return;
    end
    cmpBit(sawReq, nFetch(m) != 2'h0);
    if (nFetch(m) != 2'h0)
      cmpWord(firstAddr, opc + 16'h1);
    cmpByte({5'h00, instrLen}, {5'h00, lenOf(m, y)});
    cmpWord(pcNext, pc);
    if (nFetch(m) != 2'h0)
      cmpByte(operand, b0);
    case (m)
      MODE_DIRL: ea = {b0, b1};
      MODE_IDX0: ea = {8'h00, idx};
      MODE_IDXS: ea = {8'h00, b0} + {8'h00, idx};
      MODE_IDXL: ea = {b0, b1} + {8'h00, idx};
      MODE_INDS, MODE_BITI, MODE_BITIR: ea = {8'h00, q0};
      MODE_INDL: ea = {q0, q1};
      MODE_INDIS: ea = {8'h00, q0} + {8'h00, idx};
      MODE_INDIL: ea = {q0, q1} + {8'h00, idx};
      default: ea = {8'h00, b0};
    endcase
    if (!(m inside {MODE_INH, MODE_IMM, MODE_RELD, MODE_RELI}))
      cmpWord(effAddr, ea);
    off = (m == MODE_RELD) ? b0 : (m == MODE_RELI) ? q0 : b1;
    if (m inside {MODE_RELD, MODE_RELI, MODE_BITDR, MODE_BITIR})
      cmpWord(branchTarget, pc + {{8{off[7]}}, off});
    if (quick)
    begin
      // Start was lowered in this step; keep it low over one edge
      @(posedge ref_clk);
      #1;
    end
  endtask

  initial
  begin
    logic [31:0] r;
    r = $urandom(32'hf36a);
    repeat (20) @(posedge ref_clk);
    #1;
    cmpBit(busy, 1'b0);
    cmpBit(memReq, 1'b0);
    cmpBit(done, 1'b0);
    sys_rst = 1'b0;
    runOne(MODE_IDXS, 1'b0, 1'b0, 16'h0059, 8'hff, 8'h00, 1'b0);
    runOne(MODE_IDX0, 1'b1, 1'b0, 16'h1234, 8'h11, 8'hff, 1'b0);
    runOne(MODE_IDX0, 1'b0, 1'b0, 16'h4321, 8'h80, 8'h7f, 1'b1);
    runOne(MODE_DIRL, 1'b0, 1'b0, 16'hfffe, 8'h00, 8'h00, 1'b1);
    runOne(MODE_INH, 1'b0, 1'b0, 16'hffff, 8'h00, 8'h00, 1'b0);
    for (int i = 0; i < 17; i++)
    begin
      r = $urandom;
      runOne(amd_mode_e'(i[4:0]), r[0], 1'b1, r[31:16], r[15:8], r[7:0], 1'b0);
    end
    // Reset in the middle of a fetch drops the decode at once
    start = 1'b1;
    modeIn = MODE_BITIR;
    rmwIn = 1'b0;
    @(posedge ref_clk);
    #1;
    start = 1'b0;
    @(posedge ref_clk);
    #1;
    sys_rst = 1'b1;
    #1;
    cmpBit(busy, 1'b0);
    cmpBit(memReq, 1'b0);
    cmpBit(done, 1'b0);
    cmpByte({5'h00, instrLen}, 8'h00);
    @(posedge ref_clk);
    #1;
    sys_rst = 1'b0;
    repeat (8)
    begin
      for (int i = 0; i < 17; i++)
      begin
        r = $urandom;
        runOne(amd_mode_e'(i[4:0]), r[0], 1'b0, r[31:16], r[15:8], r[7:0], r[1]);
      end
    end
    conclude();
  end
endmodule

/* File: bench/amd_mem_model.sv */
// Program and data memory model answering decoder fetches with a chosen lag
`timescale 1ns/1ns
module amd_mem_model
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic memReq,
  input wire logic [15:0] memAddr,
  input wire logic [1:0] lag,
  output logic [7:0] memRdata,
  output logic memRvalid
);
  logic [1:0] waitCnt;

  // Content is a fixed function of the address; one byte per pulse, never two pulses in a row
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      memRvalid <= 1'b0;
      memRdata <= 8'h00;
      waitCnt <= 2'h0;
    end
    else if (memReq && !memRvalid && waitCnt >= lag)
    begin
      memRvalid <= 1'b1;
      memRdata <= memAddr[7:0] ^ memAddr[15:8] ^ 8'ha5;
      waitCnt <= 2'h0;
    end
    else
    begin
      // Stale data is inverted so it never looks valid
      memRvalid <= 1'b0;
      memRdata <= ~memRdata;
      waitCnt <= (memReq && waitCnt != 2'h3) ? waitCnt + 2'h1 : 2'h0;
    end
  end
endmodule

/* File: design/amd_decoder.sv */
// Operand addressing-mode decoder and effective address sequencer
// Notes on behaviour
// RQ1 - Inherent instructions are one byte; nothing is fetched after the opcode.
// RQ2 - Immediate takes opcode plus one operand byte used as the value.
// RQ3 - Short direct address is the following byte, page zero only.
// RQ4 - Long direct address is the following 16-bit word, high byte first.
// RQ5 - Indexed address is unsigned sum of X or Y and the offset.
// RQ6 - No-offset indexed fetches nothing; index alone addresses 00 to FF.
// RQ7 - No-offset indexed adds zero bytes with X, one prefix byte with Y.
// RQ8 - Short forms reach page zero only; short indexed sums carry up to 01FE.
// RQ9 - Long forms reach the whole 64 Kbyte space.
// RQ10 - Read-modify-write instructions refuse long forms.
// RQ11 - Relative targets count from the address of the next instruction.
// RQ12 - Short indexed uses one offset byte, long indexed a word.
// RQ13 - Short indirect reads a byte pointer, long indirect a word pointer.
// RQ14 - Indirect indexed adds X or Y to a pointer read from page zero.
// RQ15 - Relative adds a signed byte, direct or read through a pointer.
// RQ16 - Bit forms add one, two, two or three bytes.
// RQ17 - Indirect forms count the prefix and fetch the pointer first; the code reads the pointer after the operand bytes.
`timescale 1ns/1ns
module amd_decoder
  import amd_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic start,
  input wire amd_mode_e modeIn,
  input wire logic useYIn,
  input wire logic rmwIn,
  input wire logic [15:0] opcodeAddr,
  input wire logic [7:0] xReg,
  input wire logic [7:0] yReg,
  output logic memReq,
  output logic [15:0] memAddr,
  input wire logic [7:0] memRdata,
  input wire logic memRvalid,
  output logic busy,
  output logic done,
  output logic illegal,
  output logic [15:0] effAddr,
  output logic [7:0] operand,
  output logic [15:0] branchTarget,
  output logic [15:0] pcNext,
  output logic [2:0] instrLen
);

  typedef struct packed {
    amd_state_e st;
    amd_mode_e mode;
    logic useY;
    logic [1:0] nFetch;
    logic [1:0] nPtr;
    logic [1:0] cnt;
    logic [7:0] b0;
    logic [7:0] b1;
    logic [7:0] p0;
    logic [7:0] p1;
    logic [7:0] idx;
    logic [15:0] memAddr;
    logic [15:0] opcAddr;
    logic done;
    logic illegal;
    logic [15:0] effAddr;
    logic [7:0] operand;
    logic [15:0] target;
    logic [15:0] pcNext;
    logic [2:0] instrLen;
  } amd_core_s;

  amd_core_s q;
  amd_core_s d;
  amd_ea_if ea ();

  amd_ea_adder u_adder (
    .ea(ea.calc)
  );

  // Operand selection for the adder
  always_comb
  begin
    ea.base = ADDR_RESET;
    ea.useIdx = 1'b0;
    ea.relOff = q.b0;
    ea.index = q.idx;
    ea.relBase = q.opcAddr + {14'h0000, q.nFetch} + {13'h0000, OPCODE_BYTES};
    case (q.mode)
      MODE_DIRS, MODE_BITD, MODE_BITDR: ea.base = {PAGE_ZERO, q.b0}; // see RQ3 see RQ8
      MODE_DIRL: ea.base = {q.b0, q.b1}; // see RQ4 see RQ9
      MODE_IDX0: ea.useIdx = 1'b1; // see RQ6
      MODE_IDXS:
      begin
        ea.base = {PAGE_ZERO, q.b0}; // see RQ12
        ea.useIdx = 1'b1;
      end
      MODE_IDXL:
      begin
        ea.base = {q.b0, q.b1}; // see RQ12
        ea.useIdx = 1'b1;
      end
      MODE_INDS, MODE_BITI, MODE_BITIR: ea.base = {PAGE_ZERO, q.p0}; // see RQ13
      MODE_INDL: ea.base = {q.p0, q.p1}; // see RQ13
      MODE_INDIS:
      begin
        ea.base = {PAGE_ZERO, q.p0}; // see RQ14
        ea.useIdx = 1'b1;
      end
      MODE_INDIL:
      begin
        ea.base = {q.p0, q.p1}; // see RQ14
        ea.useIdx = 1'b1;
      end
      default: ea.base = ADDR_RESET;
    endcase
    case (q.mode)
      MODE_RELI: ea.relOff = q.p0; // see RQ15
      MODE_BITDR, MODE_BITIR: ea.relOff = q.b1;
      default: ea.relOff = q.b0;
    endcase
  end

  // Sequencer
  always_comb
  begin
    d = q;
    d.done = 1'b0;
    d.illegal = 1'b0;
    case (q.st)
      ST_IDLE:
      begin
        if (start)
        begin
          d.mode = modeIn;
          d.useY = useYIn;
          d.idx = useYIn ? yReg : xReg;
          d.opcAddr = opcodeAddr;
          d.nFetch = fetchCount(modeIn); // see RQ1 see RQ2
          d.nPtr = ptrCount(modeIn);
          d.cnt = 2'h0;
          d.memAddr = opcodeAddr + 16'h0001;
          d.instrLen = {1'b0, lenAdd(modeIn, useYIn)} + OPCODE_BYTES; // see RQ7 see RQ16 see RQ17
          if (rmwIn && isLong(modeIn))
            d.illegal = 1'b1; // see RQ10
          else if (fetchCount(modeIn) == 2'h0)
            d.st = ST_FINISH; // see RQ1 see RQ6
          else
            d.st = ST_FETCH;
        end
      end
      ST_FETCH:
      begin
        if (memRvalid)
        begin
          if (q.cnt == 2'h0)
            d.b0 = memRdata;
          else
            d.b1 = memRdata;
          d.cnt = q.cnt + 2'h1;
          d.memAddr = q.memAddr + 16'h0001;
          if (q.cnt + 2'h1 == q.nFetch)
          begin
            d.cnt = 2'h0;
            if (q.nPtr != 2'h0)
            begin
              d.st = ST_PTR;
              // Pointer lives in page zero at the first fetched byte, see RQ17
              d.memAddr = {PAGE_ZERO, (q.cnt == 2'h0) ? memRdata : q.b0};
            end
            else
              d.st = ST_FINISH;
          end
        end
      end
      ST_PTR:
      begin
        if (memRvalid)
        begin
          if (q.cnt == 2'h0)
            d.p0 = memRdata;
          else
            d.p1 = memRdata;
          d.cnt = q.cnt + 2'h1;
          d.memAddr = q.memAddr + 16'h0001;
          if (q.cnt + 2'h1 == q.nPtr)
            d.st = ST_FINISH;
        end
      end
      ST_FINISH:
      begin
        d.st = ST_IDLE;
        d.done = 1'b1;
        d.effAddr = ea.effAddr;
        d.operand = q.b0; // see RQ2
        d.target = ea.target; // see RQ11
        d.pcNext = ea.relBase;
      end
      default: d.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      q <= '{st: ST_IDLE, mode: MODE_INH, useY: 1'b0, nFetch: 2'h0, nPtr: 2'h0, cnt: 2'h0,
             b0: BYTE_RESET, b1: BYTE_RESET, p0: BYTE_RESET, p1: BYTE_RESET, idx: BYTE_RESET,
             memAddr: ADDR_RESET, opcAddr: ADDR_RESET, done: 1'b0, illegal: 1'b0,
             effAddr: ADDR_RESET, operand: BYTE_RESET, target: ADDR_RESET, pcNext: ADDR_RESET,
             instrLen: 3'h0};
    end
    else
      q <= d;
  end

  assign memReq = (q.st == ST_FETCH) || (q.st == ST_PTR);
  assign memAddr = q.memAddr;
  assign busy = (q.st != ST_IDLE);
  assign done = q.done;
  assign illegal = q.illegal;
  assign effAddr = q.effAddr;
  assign operand = q.operand;
  assign branchTarget = q.target;
  assign pcNext = q.pcNext;
  assign instrLen = q.instrLen;

  property p_inherent_one_byte;
    @(posedge ref_clk) disable iff (sys_rst)
    (start && !busy && modeIn == MODE_INH && !rmwIn) |-> ##2 (done && instrLen == 3'h1 && !memReq);
  endproperty
  a_inherent_one_byte: assert property (p_inherent_one_byte) else $error("inherent length wrong"); // see RQ1

  property p_immediate_two;
    @(posedge ref_clk) disable iff (sys_rst)
    (done && q.mode == MODE_IMM) |-> (instrLen == 3'h2 && operand == $past(memRdata, 2) && $past(memRvalid, 2));
  endproperty
  a_immediate_two: assert property (p_immediate_two) else $error("immediate operand wrong"); // see RQ2

  property p_short_direct;
    @(posedge ref_clk) disable iff (sys_rst)
    (done && q.mode == MODE_DIRS) |-> (effAddr == {8'h00, q.b0});
  endproperty
  a_short_direct: assert property (p_short_direct) else $error("short direct address wrong"); // see RQ3

  property p_long_direct;
    @(posedge ref_clk) disable iff (sys_rst)
    (done && q.mode == MODE_DIRL) |-> (effAddr == {q.b0, q.b1} && instrLen == 3'h3);
  endproperty
  a_long_direct: assert property (p_long_direct) else $error("long direct address wrong"); // see RQ4

  property p_index_short;
    @(posedge ref_clk) disable iff (sys_rst)
    (done && q.mode == MODE_IDXS) |-> (effAddr == {8'h00, q.b0} + {8'h00, q.idx});
  endproperty
  a_index_short: assert property (p_index_short) else $error("indexed sum wrong"); // see RQ5

  property p_index_none;
    @(posedge ref_clk) disable iff (sys_rst)
    (done && q.mode == MODE_IDX0) |-> (effAddr == {8'h00, q.idx} && instrLen == (q.useY ? 3'h2 : 3'h1));
  endproperty
  a_index_none: assert property (p_index_none) else $error("no-offset indexed wrong"); // see RQ7

  property p_rmw_long_refused;
    @(posedge ref_clk) disable iff (sys_rst)
    (start && !busy && rmwIn && isLong(modeIn)) |=> (illegal && !busy) ##1 !done;
  endproperty
  a_rmw_long_refused: assert property (p_rmw_long_refused) else $error("long read-modify-write taken"); // see RQ10

  property p_rel_target;
    @(posedge ref_clk) disable iff (sys_rst)
    (done && q.mode == MODE_RELD) |-> (branchTarget == pcNext + {{8{q.b0[7]}}, q.b0}
      && pcNext == q.opcAddr + 16'h0002);
  endproperty
  a_rel_target: assert property (p_rel_target) else $error("relative target wrong"); // see RQ11

  property p_ptr_page_zero;
    @(posedge ref_clk) disable iff (sys_rst)
    ($rose(q.st == ST_PTR)) |-> (memReq && memAddr[15:8] == 8'h00 && $past(q.st) == ST_FETCH);
  endproperty
  a_ptr_page_zero: assert property (p_ptr_page_zero) else $error("pointer not in page zero"); // see RQ17

  property p_bit_ind_rel_len;
    @(posedge ref_clk) disable iff (sys_rst)
    (done && q.mode == MODE_BITIR) |-> (instrLen == 3'h4 && effAddr == {8'h00, q.p0});
  endproperty
  a_bit_ind_rel_len: assert property (p_bit_ind_rel_len) else $error("bit indirect relative wrong"); // see RQ16

  c_rel_indirect: cover property (@(posedge ref_clk) disable iff (sys_rst) done && q.mode == MODE_RELI);
  c_ind_idx_long: cover property (@(posedge ref_clk) disable iff (sys_rst) done && q.mode == MODE_INDIL);
  c_bit_ind_rel: cover property (@(posedge ref_clk) disable iff (sys_rst) done && q.mode == MODE_BITIR);
  c_refused: cover property (@(posedge ref_clk) disable iff (sys_rst) illegal);

endmodule

/* File: design/amd_ea_adder.sv */
// Effective address and relative target adder
`timescale 1ns/1ns
module amd_ea_adder
  import amd_pkg::*;
(
  amd_ea_if.calc ea
);
  logic [15:0] idxExt;
  logic [15:0] offExt;

  assign idxExt = ea.useIdx ? {8'h00, ea.index} : 16'h0000;
  // Unsigned base plus index, see RQ5 see RQ14
  assign ea.effAddr = ea.base + idxExt;
  // Signed offset from the following instruction, see RQ11 see RQ15
  assign offExt = {{8{ea.relOff[7]}}, ea.relOff};
  assign ea.target = ea.relBase + offExt;
endmodule

/* File: design/amd_ea_if.sv */
// Interface between the decoder sequencer and its address adder
`timescale 1ns/1ns
interface amd_ea_if;
  logic [15:0] base;
  logic [7:0] index;
  logic useIdx;
  logic [15:0] relBase;
  logic [7:0] relOff;
  logic [15:0] effAddr;
  logic [15:0] target;
  modport seq (output base, output index, output useIdx, output relBase, output relOff,
               input effAddr, input target);
  modport calc (input base, input index, input useIdx, input relBase, input relOff,
                output effAddr, output target);
endinterface

/* File: design/amd_pkg.sv */
// Package with modes, states, lengths and reset values of the addressing-mode decoder
package amd_pkg;

  typedef enum logic [4:0] {
    MODE_INH = 5'h00, MODE_IMM = 5'h01, MODE_DIRS = 5'h02, MODE_DIRL = 5'h03,
    MODE_IDX0 = 5'h04, MODE_IDXS = 5'h05, MODE_IDXL = 5'h06, MODE_INDS = 5'h07,
    MODE_INDL = 5'h08, MODE_INDIS = 5'h09, MODE_INDIL = 5'h0a, MODE_RELD = 5'h0b,
    MODE_RELI = 5'h0c, MODE_BITD = 5'h0d, MODE_BITI = 5'h0e, MODE_BITDR = 5'h0f,
    MODE_BITIR = 5'h10
  } amd_mode_e;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1, ST_FETCH = 4'h2, ST_PTR = 4'h4, ST_FINISH = 4'h8
  } amd_state_e;

  localparam logic [15:0] ADDR_RESET = 16'h0000;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [7:0] PAGE_ZERO = 8'h00;
  localparam logic [2:0] OPCODE_BYTES = 3'h1;

  // Bytes after the opcode that the decoder fetches
  function automatic logic [1:0] fetchCount(amd_mode_e m);
    case (m)
      MODE_INH, MODE_IDX0: fetchCount = 2'h0;
      MODE_DIRL, MODE_IDXL, MODE_BITDR, MODE_BITIR: fetchCount = 2'h2;
      default: fetchCount = 2'h1;
    endcase
  endfunction

  // Pointer bytes fetched from page zero
  function automatic logic [1:0] ptrCount(amd_mode_e m);
    case (m)
      MODE_INDS, MODE_INDIS, MODE_RELI, MODE_BITI, MODE_BITIR: ptrCount = 2'h1;
      MODE_INDL, MODE_INDIL: ptrCount = 2'h2;
      default: ptrCount = 2'h0;
    endcase
  endfunction

  // Bytes added to the opcode, prefix byte included
  function automatic logic [1:0] lenAdd(amd_mode_e m, logic useY);
    case (m)
      MODE_INH: lenAdd = 2'h0;
      MODE_IDX0: lenAdd = useY ? 2'h1 : 2'h0;
      MODE_IMM, MODE_DIRS, MODE_IDXS, MODE_RELD, MODE_BITD: lenAdd = 2'h1;
      MODE_BITIR: lenAdd = 2'h3;
      default: lenAdd = 2'h2;
    endcase
  endfunction

  function automatic logic isLong(amd_mode_e m);
    isLong = (m == MODE_DIRL) || (m == MODE_IDXL) || (m == MODE_INDL) || (m == MODE_INDIL);
  endfunction

endpackage
